// ===== logic/cph_top.sv
// Configuration port handshake and status pin logic.
`timescale 1ns/1ps
`include "cph_defs.svh"
module cph_top
    import cph_pkg::*;
#(
    parameter int STAB_CYCLES  = `CPH_STAB_CYCLES,
    parameter int CLEAR_CYCLES = `CPH_CLEAR_CYCLES,
    parameter int CFG_BYTES    = `CPH_CFG_BYTES,
    parameter int FIFO_DEPTH   = `CPH_FIFO_DEPTH
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire cph_mode_e    mode,
    input  wire logic         micro_port_used,
    input  wire cph_strobes_s strobes,
    input  wire logic [7:0]   data_in,
    input  wire logic         init_n_in,
    output logic              init_n_out,
    output logic              init_n_oe,
    output logic              ready_out,
    output logic              ready_oe,
    output logic              d7_out,
    output logic              d7_oe,
    output logic              cfg_pending_high,
    output logic              cfg_pending_high_oe,
    output logic              cfg_pending_low,
    output logic              cfg_pending_low_oe,
    output logic              micro_port_transfer_strobe,
    output logic [7:0]        cfg_byte,
    output logic              cfg_byte_valid,
    input  wire logic         cfg_byte_ready,
    output logic              cfg_done
);
    // Counts that the sequencer cannot serve are refused while the design is elaborated.
    if (STAB_CYCLES < 1 || CLEAR_CYCLES < 1 || CFG_BYTES < 1 || FIFO_DEPTH < 2)
    begin
        $error("cph_top counts out of range");
    end
    // =========================================================
    // Input synchronisers
    // =========================================================
    cph_strobes_s strb_s1_reg;
    cph_strobes_s strb_reg;
    logic [7:0]   data_s1_reg;
    logic [7:0]   data_reg;
    logic         init_s1_reg;
    logic         init_reg;
    logic         wr_prev_reg;
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            strb_s1_reg <= '{1'b1, 1'b0, 1'b1, 1'b1};
            strb_reg    <= '{1'b1, 1'b0, 1'b1, 1'b1};
            data_s1_reg <= 8'h00;
            data_reg    <= 8'h00;
            init_s1_reg <= 1'b1;
            init_reg    <= 1'b1;
            wr_prev_reg <= 1'b1;
        end
        else
        begin
            strb_s1_reg <= strobes;
            strb_reg    <= strb_s1_reg;
            data_s1_reg <= data_in;
            data_reg    <= data_s1_reg;
            init_s1_reg <= init_n_in;
            init_reg    <= init_s1_reg;
            wr_prev_reg <= strb_reg.wr_n;
        end
    end
    logic selected;
    logic wr_act;
    logic rd_act;
    logic wr_take;
    logic fifo_in_ready;
    logic [7:0] rclk_div_reg;
    logic       rclk_reg;
    logic       rclk_fall;
    logic [7:0] fifo_out_data;
    logic       fifo_out_valid;
    logic       fifo_out_ready;
    assign selected = !strb_reg.select_active_low_n && strb_reg.select_active_high;
    assign wr_act   = selected && !strb_reg.wr_n;
    assign rd_act   = selected && !strb_reg.rd_n && strb_reg.wr_n;
    // =========================================================
    // Configuration sequencer
    // =========================================================
    cph_state_e state_reg;
    logic [31:0] cnt_reg;
    logic        loading;
    assign loading = (state_reg == CPH_ST_LOAD);
    assign wr_take = loading && wr_act && wr_prev_reg && fifo_in_ready && mode != CPH_MODE_MASTER_PAR;
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            state_reg <= CPH_ST_STAB;
            cnt_reg   <= 32'h0000_0000;
        end
        else
        begin
            case (state_reg)
                CPH_ST_STAB:
                begin
                    cnt_reg <= cnt_reg + 32'h0000_0001;
                    if (cnt_reg >= 32'(STAB_CYCLES - 1))
                    begin
                        state_reg <= CPH_ST_CLEAR;
                        cnt_reg   <= 32'h0000_0000;
                    end
                end
                CPH_ST_CLEAR:
                begin
                    cnt_reg <= cnt_reg + 32'h0000_0001;
                    if (cnt_reg >= 32'(CLEAR_CYCLES - 1))
                    begin
                        state_reg <= CPH_ST_WAIT;
                        cnt_reg   <= 32'h0000_0000;
                    end
                end
                CPH_ST_WAIT:
                begin
                    if (init_reg) state_reg <= CPH_ST_LOAD;
                end
                CPH_ST_LOAD:
                begin
                    if (wr_take || (mode == CPH_MODE_MASTER_PAR && rclk_fall))
                    begin
                        cnt_reg <= cnt_reg + 32'h0000_0001;
                        if (cnt_reg >= 32'(CFG_BYTES - 1)) state_reg <= CPH_ST_DONE;
                    end
                end
                CPH_ST_DONE:
                begin
                    state_reg <= CPH_ST_DONE;
                end
                default:
                begin
                    state_reg <= CPH_ST_STAB;
                end
            endcase
        end
    end
    // =========================================================
    // Master parallel read strobe toward external memory
    // =========================================================
    assign rclk_fall = rclk_reg && (rclk_div_reg == 8'(`CPH_RCLK_DIV - 1)) && fifo_in_ready;
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            rclk_div_reg <= 8'h00;
            rclk_reg     <= 1'b1;
        end
        else if (loading && mode == CPH_MODE_MASTER_PAR)
        begin
            rclk_div_reg <= (rclk_div_reg == 8'(`CPH_RCLK_DIV - 1)) ? 8'h00 : rclk_div_reg + 8'h01;
            if (rclk_div_reg == 8'(`CPH_RCLK_DIV - 1) && (fifo_in_ready || !rclk_reg)) rclk_reg <= !rclk_reg;
        end
        else
        begin
            rclk_div_reg <= 8'h00;
            rclk_reg     <= 1'b1;
        end
    end
    // =========================================================
    // Byte buffer toward the configuration memory
    // =========================================================
    cph_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock    (clock),
        .nrst     (nrst),
        .in_data  (data_reg),
        .in_valid (wr_take || (loading && mode == CPH_MODE_MASTER_PAR && rclk_fall)),
        .in_ready (fifo_in_ready),
        .out_data (fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready)
    );
    // =========================================================
    // Output register of the byte stream
    // =========================================================
    // A word moves on whenever the register is empty or being taken, so the
    // stream keeps its full rate while its outputs come straight from flip-flops.
    assign fifo_out_ready = !cfg_byte_valid || cfg_byte_ready;
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            cfg_byte       <= 8'h00;
            cfg_byte_valid <= 1'b0;
        end
        else if (fifo_out_ready)
        begin
            cfg_byte_valid <= fifo_out_valid;
            if (fifo_out_valid) cfg_byte <= fifo_out_data;
        end
    end
    // =========================================================
    // Pin drivers
    // =========================================================
    logic done;
    assign done = (state_reg == CPH_ST_DONE);
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            init_n_out                 <= 1'b0;
            init_n_oe                  <= 1'b1;
            ready_out                  <= 1'b0;
            ready_oe                   <= 1'b1;
            d7_out                     <= 1'b0;
            d7_oe                      <= 1'b0;
            cfg_pending_high           <= 1'b1;
            cfg_pending_high_oe        <= 1'b1;
            cfg_pending_low            <= 1'b0;
            cfg_pending_low_oe         <= 1'b1;
            micro_port_transfer_strobe <= 1'b0;
            cfg_done                   <= 1'b0;
        end
        else
        begin
            init_n_out <= 1'b0;
            init_n_oe  <= (state_reg == CPH_ST_STAB || state_reg == CPH_ST_CLEAR);
            if (mode == CPH_MODE_MASTER_PAR && !done) ready_out <= rclk_reg;
            else ready_out <= loading && fifo_in_ready && !wr_act;
            ready_oe  <= !done || micro_port_used;
            d7_out    <= loading && fifo_in_ready && !wr_act;
            d7_oe     <= !done && mode == CPH_MODE_PERIPH_ASYNC && rd_act;
            cfg_pending_high    <= !done;
            cfg_pending_high_oe <= !done;
            cfg_pending_low     <= done;
            cfg_pending_low_oe  <= !done;
            micro_port_transfer_strobe <= micro_port_used && selected && !strb_reg.rd_n;
            cfg_done <= done;
        end
    end
endmodule

// ===== logic/cph_defs.svh
// Constants for the configuration port handshake block.
`ifndef CPH_DEFS_SVH
`define CPH_DEFS_SVH
// Notes on behaviour
// - Ready high while another byte fits.
// - Selected read shows ready on bit 7 in peripheral async mode only.
// - Master parallel drives ready pin as strobe.
// - High pending output high until done.
// - Low pending output low until done.
// - Init pulled low during stabilise and clear.
// - Init held low externally keeps wait state.
// - Selected only when low-select low, high-select high.
// - Read strobe low makes bit 7 status.
// - Write strobe wins over simultaneous read for bit 7 status only.
// - Read strobe doubles as micro port strobe.
// - Pins released after done; ready kept if micro port.
`define CPH_CLK_PERIOD_NS 10
`define CPH_STAB_TIME_NS  200
`define CPH_STAB_CYCLES   ((`CPH_STAB_TIME_NS + `CPH_CLK_PERIOD_NS - 1) / `CPH_CLK_PERIOD_NS)
`define CPH_CLEAR_CYCLES  64
`define CPH_CFG_BYTES     256
`define CPH_STATUS_BIT    7
`define CPH_RCLK_DIV      4
`define CPH_FIFO_DEPTH    8
`endif

// ===== logic/cph_pkg.sv
// Types for the configuration port handshake block.
package cph_pkg;
    typedef enum logic [2:0] {
        CPH_ST_STAB  = 3'b000,
        CPH_ST_CLEAR = 3'b001,
        CPH_ST_WAIT  = 3'b010,
        CPH_ST_LOAD  = 3'b011,
        CPH_ST_DONE  = 3'b100
    } cph_state_e;
    typedef enum logic [1:0] {
        CPH_MODE_PERIPH_ASYNC = 2'b00,
        CPH_MODE_SLAVE_PAR    = 2'b01,
        CPH_MODE_MICRO_PORT   = 2'b10,
        CPH_MODE_MASTER_PAR   = 2'b11
    } cph_mode_e;
    typedef struct packed {
        logic select_active_low_n;
        logic select_active_high;
        logic wr_n;
        logic rd_n;
    } cph_strobes_s;
    typedef struct packed {
        logic o;
        logic oe;
    } cph_pin_s;
endpackage

// ===== logic/cph_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module cph_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH)
    begin
        $error("cph_fifo depth must be a power of two");
    end
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;
    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != '0);
    assign out_data  = mem_reg[rd_ptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    always_ff @(posedge clock)
    begin
        if (push) mem_reg[wr_ptr_reg] <= in_data;
    end
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (push && !pop) count_reg <= count_reg + 1'b1;
            else if (pop && !push) count_reg <= count_reg - 1'b1;
        end
    end
endmodule

// ===== bench/cph_top_monitor.sv
// Checker for the configuration port handshake pins.
`timescale 1ns/1ps
module cph_top_monitor
    import cph_pkg::*;
(
    input wire logic         clock,
    input wire logic         nrst,
    input wire cph_mode_e    mode,
    input wire logic         micro_port_used,
    input wire cph_strobes_s strobes,
    input wire logic         init_n_in,
    input wire logic         init_n_out,
    input wire logic         init_n_oe,
    input wire logic         ready_out,
    input wire logic         d7_out,
    input wire logic         d7_oe,
    input wire logic         cfg_pending_high,
    input wire logic         cfg_pending_high_oe,
    input wire logic         cfg_pending_low,
    input wire logic         cfg_pending_low_oe,
    input wire logic         micro_port_transfer_strobe,
    input wire logic         cfg_done
);
    logic sel;
    assign sel = !strobes.select_active_low_n && strobes.select_active_high;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    // ========================================
    // Pin relations.
    a_init_low: assert property (init_n_oe |-> !init_n_out) else $error("init driven high");
    a_init_after_reset: assert property ($rose(nrst) |-> init_n_oe [*3]) else $error("init released early");
    a_pend_high: assert property (cfg_pending_high_oe |-> cfg_pending_high) else $error("pending high wrong");
    a_pend_low: assert property (cfg_pending_low_oe |-> !cfg_pending_low) else $error("pending low wrong");
    a_release_done: assert property ($rose(cfg_done)
        |-> ##[0:2] (!cfg_pending_high_oe && !cfg_pending_low_oe)) else $error("pending pins kept");
    a_ready_busy: assert property ((!strobes.wr_n && sel && mode != CPH_MODE_MASTER_PAR && !cfg_done) [*6]
        |-> !ready_out) else $error("ready high during write");
    a_select_needed: assert property (!sel [*5] |-> !d7_oe && !micro_port_transfer_strobe)
        else $error("acts unselected");
    a_write_wins: assert property (!strobes.wr_n [*5] |-> !d7_oe) else $error("read beat write");
    a_status_mode: assert property (d7_oe |-> mode == CPH_MODE_PERIPH_ASYNC) else $error("status in wrong mode");
    a_status_match: assert property (d7_oe && $past(d7_oe) && $stable(ready_out) |-> d7_out == ready_out)
        else $error("status differs from ready");
    a_micro_used: assert property (micro_port_transfer_strobe |-> micro_port_used) else $error("micro strobe");
    // The strobe idles high until loading starts, a few cycles after the init line is seen released.
    a_master_strobe: assert property (ready_out && mode == CPH_MODE_MASTER_PAR && !cfg_done
        && init_n_in && !init_n_oe |-> ##[1:10] (!ready_out || cfg_done || !init_n_in))
        else $error("read strobe stuck");
endmodule
bind cph_top cph_top_monitor u_mon (.clock, .nrst, .mode, .micro_port_used, .strobes, .init_n_in, .init_n_out,
    .init_n_oe,
    .ready_out, .d7_out, .d7_oe, .cfg_pending_high, .cfg_pending_high_oe, .cfg_pending_low, .cfg_pending_low_oe,
    .micro_port_transfer_strobe, .cfg_done);

// ===== bench/cph_host_model.sv
// Host model that loads bytes over the parallel port.
`timescale 1ns/1ps
module cph_host_model
    import cph_pkg::*;
(
    input  wire logic   clock,
    input  wire logic   ready,
    output cph_strobes_s strobes,
    output logic [7:0]  data_in
);
    initial
    begin
        strobes = 4'hB;
        data_in = 8'h00;
    end
    // Waits for ready, then one write pulse; released data shows the inverse.
    task automatic put(input logic [7:0] b, input logic [1:0] sel, input logic rd);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 100)
        begin
            @(negedge clock);
            n++;
        end
        @(negedge clock);
        strobes = {sel, 1'b0, !rd};
        data_in = b;
        repeat (6) @(negedge clock);
        strobes = 4'hB;
        data_in = ~b;
        repeat (4) @(negedge clock);
    endtask
    task automatic rd(input logic on);
        @(negedge clock);
        strobes = on ? 4'h6 : 4'hB;
    endtask
endmodule

// ===== bench/cph_top_tb.sv
// Self-checking bench of the configuration port handshake block.
`timescale 1ns/1ps
`include "cph_defs.svh"
module cph_top_tb
    import cph_pkg::*;
;
    localparam int NB = 10;
    // Eight buffered words and the output register are full after nine bytes.
    localparam int HOLD = 9;
    logic clock, nrst, micro_port_used, init_n_in, init_hold, drain, cfg_byte_ready, cfg_byte_valid, cfg_done;
    logic init_n_out, init_n_oe, ready_out, ready_oe, d7_out, d7_oe, micro_port_transfer_strobe;
    logic cfg_pending_high, cfg_pending_high_oe, cfg_pending_low, cfg_pending_low_oe;
    cph_mode_e    mode;
    cph_strobes_s strobes;
    logic [7:0]   data_in, cfg_byte;
    logic [7:0]   exp_q[$];
    int           mismatches, samples_checked, seed;
    cph_top #(.STAB_CYCLES(2), .CLEAR_CYCLES(2), .CFG_BYTES(NB)) DUT (.clock, .nrst, .mode, .micro_port_used,
        .strobes, .data_in, .init_n_in, .init_n_out, .init_n_oe, .ready_out, .ready_oe, .d7_out, .d7_oe,
        .cfg_pending_high, .cfg_pending_high_oe, .cfg_pending_low, .cfg_pending_low_oe,
        .micro_port_transfer_strobe, .cfg_byte, .cfg_byte_valid, .cfg_byte_ready, .cfg_done);
    cph_host_model host (.clock, .ready(ready_out && ready_oe), .strobes, .data_in);
    assign init_n_in = !(init_n_oe || init_hold);
    // ========================================
    // Checking and draining.
    task automatic check(input logic ok, input string msg);
        samples_checked++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(negedge clock)
        cfg_byte_ready <= drain && (mode == CPH_MODE_MASTER_PAR || $random(seed) % 2 == 0);
    always @(posedge clock)
        if (cfg_byte_valid === 1'b1 && cfg_byte_ready === 1'b1 && mode != CPH_MODE_MASTER_PAR)
        begin
            check(exp_q.size() > 0 && cfg_byte === exp_q[0], "byte order");
            if (exp_q.size() > 0)
                void'(exp_q.pop_front());
        end
    // ========================================
    // One configuration run in a given mode.
    task automatic run(input cph_mode_e m);
        logic [7:0] b;
        int n;
        nrst = 1'b0;
        mode = m;
        micro_port_used = (m == CPH_MODE_MICRO_PORT);
        drain = (m == CPH_MODE_MASTER_PAR);
        init_hold = 1'b1;
        repeat (3) @(negedge clock);
        check(init_n_oe === 1'b1 && cfg_pending_high === 1'b1 && cfg_pending_low === 1'b0, "reset pins");
        nrst = 1'b1;
        repeat (30) @(negedge clock);
        check(cfg_pending_high_oe === 1'b1 && init_n_oe === 1'b0 && ready_out === (m == CPH_MODE_MASTER_PAR),
            "wait state");
        host.put(8'hA5, 2'b01, 1'b0);
        init_hold = 1'b0;
        if (m == CPH_MODE_MASTER_PAR)
        begin
            repeat (10) @(negedge clock);
            n = 0;
            for (int k = 0; k < 40; k++)
            begin
                b[0] = ready_out;
                @(negedge clock);
                n += (ready_out !== b[0]);
            end
            check(ready_oe === 1'b1 && n >= 40 / `CPH_RCLK_DIV - 1, "read strobe");
        end
        else
        begin
            host.put(8'h3C, 2'b00, 1'b0);
            host.put(8'hC3, 2'b11, 1'b0);
        end
        for (int i = 0; i < NB && m != CPH_MODE_MASTER_PAR; i++)
        begin
            if (i == HOLD)
            begin
                repeat (10) @(negedge clock);
                check(ready_out === 1'b0, "full buffer");
                drain = 1'b1;
            end
            b = (i == 0) ? 8'h00 : (i == NB - 1) ? 8'hFF : 8'($random(seed));
            exp_q.push_back(b);
            host.put(b, 2'b01, i == 3);
            if (i == 4)
            begin
                host.rd(1'b1);
                repeat (6) @(negedge clock);
                check(d7_oe === (m == CPH_MODE_PERIPH_ASYNC)
                    && (d7_oe !== 1'b1 || d7_out === 1'b1 && ready_out === 1'b1), "d7");
                check(micro_port_transfer_strobe === micro_port_used, "micro strobe");
                host.rd(1'b0);
            end
        end
        repeat (60) @(negedge clock);
        check(cfg_done === 1'b1 && exp_q.size() == 0, "done");
        check(cfg_pending_high_oe === 1'b0 && cfg_pending_low_oe === 1'b0 && init_n_oe === 1'b0, "release");
        check(ready_oe === micro_port_used, "ready release");
        $display("mode %0d run ended", m);
    endtask
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial
    begin
        #100000;
        mismatches++;
        $display("[ERR] %0t watchdog", $time);
        finish_test();
    end
    initial
    begin
        seed = 21915;
        mismatches = 0;
        samples_checked = 0;
        nrst = 1'b0;
        mode = CPH_MODE_PERIPH_ASYNC;
        micro_port_used = 1'b0;
        init_hold = 1'b0;
        drain = 1'b0;
        cfg_byte_ready = 1'b0;
        for (int m = 0; m < 4; m++)
            run(cph_mode_e'(m));
        finish_test();
    end
endmodule
